// ==== sram_pkg.sv ====
// Shared constants for the synchronous pipelined SRAM cycle and lane control
package sram_pkg;
  localparam int CFG_X18 = 18;
  localparam int CFG_X32 = 32;
  localparam int CFG_X36 = 36;
  localparam int DQ_W = 36;
  localparam int LANE_W = 9;
  localparam int LANE_DATA_W = 8;
  localparam int MAX_LANES = 4;
  localparam int ADDR_PIN_W = 18;
  localparam int ADDR_W_X18 = 18;
  localparam int ADDR_W_WIDE = 17;
  localparam int EXP_PIN_W = 2;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_START = 2'h0;
  localparam logic [DQ_W-1:0] DQ_RESET = 36'h0;
  typedef enum logic [2:0] {
    ACC_IDLE = 3'h1,
    ACC_READ = 3'h2,
    ACC_WRITE = 3'h4
  } acc_state_t;
endpackage : sram_pkg

// ==== burst_order.sv ====
// Burst offset generator for linear and interleaved ordering
`timescale 1ns/1ps
module burst_order
  import sram_pkg::*;
(
  input wire logic [BURST_W-1:0] base_in,
  input wire logic [BURST_W-1:0] count_in,
  input wire logic interleave_in,
  output logic [BURST_W-1:0] offset_out
);
  always_comb begin
    if (interleave_in) begin
      offset_out = base_in ^ count_in;
    end else begin
      offset_out = BURST_W'(base_in + count_in);
    end
  end
endmodule : burst_order

// ==== sync_sram_core.sv ====
// Synchronous pipelined SRAM: cycle typing, byte lanes, burst order and array
`timescale 1ns/1ps
module sync_sram_core
  import sram_pkg::*;
#(
  parameter int WORD_CFG = CFG_X36
)
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_PIN_W-1:0] sync_address_input_in,
  input wire logic [EXP_PIN_W-1:0] reserved_expansion_pin_in,
  input wire logic advance_or_load_in,
  input wire logic read_write_in,
  input wire logic clock_enable_n_in,
  input wire logic [MAX_LANES-1:0] byte_write_lane_n_in,
  input wire logic output_enable_n_in,
  input wire logic burst_order_strap_in,
  input wire logic snooze_enable_in,
  input wire logic [DQ_W-1:0] data_lane_in,
  output logic [DQ_W-1:0] data_lane_out,
  output logic [DQ_W-1:0] data_lane_oe_out
);
  localparam int LANES = (WORD_CFG == CFG_X18) ? 2 : MAX_LANES;
  localparam int AW = (WORD_CFG == CFG_X18) ? ADDR_W_X18 : ADDR_W_WIDE;
  localparam bit PARITY_LIVE = (WORD_CFG != CFG_X32);

  logic [DQ_W-1:0] live_mask;
  logic [DQ_W-1:0] lane_we_mask;
  logic [DQ_W-1:0] bit_we;
  logic [DQ_W-1:0] mem [0:(1 << AW)-1];

  acc_state_t acc_state_r, acc_state_nxt;
  logic [AW-1:0] base_r, base_nxt;
  logic [BURST_W-1:0] cnt_r, cnt_nxt;
  logic a_valid_r, a_valid_nxt, a_write_r, a_write_nxt;
  logic [AW-1:0] a_addr_r, a_addr_nxt;
  logic [MAX_LANES-1:0] a_bw_n_r, a_bw_n_nxt;
  logic b_valid_r, b_valid_nxt, b_write_r, b_write_nxt;
  logic [AW-1:0] b_addr_r, b_addr_nxt;
  logic [MAX_LANES-1:0] b_bw_n_r, b_bw_n_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic [DQ_W-1:0] rdata_r, rdata_nxt;

  logic step, load, adv, mem_we;
  logic [BURST_W-1:0] burst_off;
  logic [AW-1:0] issue_addr;

  // Reserved expansion pins are never decoded at this density
  logic unused_exp;
  assign unused_exp = ^reserved_expansion_pin_in;

  // Snooze and suspended clock both freeze every register
  assign step = !clock_enable_n_in && !snooze_enable_in;
  assign load = step && !advance_or_load_in;
  assign adv = step && advance_or_load_in && (acc_state_r != ACC_IDLE);

  burst_order u_burst (
    .base_in(base_r[BURST_W-1:0]),
    .count_in(BURST_W'(cnt_r + 2'h1)),
    .interleave_in(burst_order_strap_in),
    .offset_out(burst_off)
  );

  genvar gi;
  generate
    for (gi = 0; gi < DQ_W; gi++) begin : g_bit
      localparam int LN = gi / LANE_W;
      localparam bit LIVE = (LN < LANES) && (((gi % LANE_W) < LANE_DATA_W) || PARITY_LIVE);
      assign live_mask[gi] = LIVE;
      assign lane_we_mask[gi] = LIVE && !b_bw_n_r[LN];
      assign bit_we[gi] = mem_we && lane_we_mask[gi];
    end
  endgenerate

  assign mem_we = step && b_valid_r && b_write_r;

  always_comb begin
    acc_state_nxt = acc_state_r;
    base_nxt = base_r;
    cnt_nxt = cnt_r;
    issue_addr = {base_r[AW-1:BURST_W], burst_off};
    if (load) begin
      acc_state_nxt = read_write_in ? ACC_READ : ACC_WRITE;
      base_nxt = sync_address_input_in[AW-1:0];
      cnt_nxt = BURST_START;
      issue_addr = sync_address_input_in[AW-1:0];
    end else if (adv) begin
      cnt_nxt = BURST_W'(cnt_r + 2'h1);
    end
  end

  always_comb begin
    a_valid_nxt = a_valid_r;
    a_write_nxt = a_write_r;
    a_addr_nxt = a_addr_r;
    a_bw_n_nxt = a_bw_n_r;
    b_valid_nxt = b_valid_r;
    b_write_nxt = b_write_r;
    b_addr_nxt = b_addr_r;
    b_bw_n_nxt = b_bw_n_r;
    rd_valid_nxt = rd_valid_r;
    rdata_nxt = rdata_r;
    if (step) begin
      a_valid_nxt = load || adv;
      a_write_nxt = load ? !read_write_in : (acc_state_r == ACC_WRITE);
      a_addr_nxt = issue_addr;
      a_bw_n_nxt = byte_write_lane_n_in;
      b_valid_nxt = a_valid_r;
      b_write_nxt = a_write_r;
      b_addr_nxt = a_addr_r;
      b_bw_n_nxt = a_bw_n_r;
      rd_valid_nxt = b_valid_r && !b_write_r;
      if (b_valid_r && !b_write_r) begin
        rdata_nxt = mem[b_addr_r] & live_mask;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_state_r <= ACC_IDLE;
      base_r <= '0;
      cnt_r <= BURST_START;
      a_valid_r <= 1'b0;
      a_write_r <= 1'b0;
      a_addr_r <= '0;
      a_bw_n_r <= '1;
      b_valid_r <= 1'b0;
      b_write_r <= 1'b0;
      b_addr_r <= '0;
      b_bw_n_r <= '1;
      rd_valid_r <= 1'b0;
      rdata_r <= DQ_RESET;
    end else begin
      acc_state_r <= acc_state_nxt;
      base_r <= base_nxt;
      cnt_r <= cnt_nxt;
      a_valid_r <= a_valid_nxt;
      a_write_r <= a_write_nxt;
      a_addr_r <= a_addr_nxt;
      a_bw_n_r <= a_bw_n_nxt;
      b_valid_r <= b_valid_nxt;
      b_write_r <= b_write_nxt;
      b_addr_r <= b_addr_nxt;
      b_bw_n_r <= b_bw_n_nxt;
      rd_valid_r <= rd_valid_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Array holds no reset; write data is taken straight off the lanes at the edge
  always_ff @(posedge clk_sys_in) begin
    for (int i = 0; i < DQ_W; i++) begin
      if (bit_we[i]) begin
        mem[b_addr_r][i] <= data_lane_in[i];
      end
    end
  end

  assign data_lane_out = rdata_r;
  assign data_lane_oe_out = (rd_valid_r && !output_enable_n_in && !snooze_enable_in) ? live_mask : '0;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);

  property p_load_type;
    load |=> acc_state_r == ($past(read_write_in) ? ACC_READ : ACC_WRITE);
  endproperty
  a_load_type: assert property (p_load_type) else $error("load did not fix access type");

  property p_select_only;
    load && read_write_in && (byte_write_lane_n_in == 4'h0) |=> acc_state_r == ACC_READ;
  endproperty
  a_select_only: assert property (p_select_only) else $error("byte enables changed access type");

  property p_type_held;
    !load |=> $stable(acc_state_r);
  endproperty
  a_type_held: assert property (p_type_held) else $error("access type changed without load");

  property p_write_uses_lanes;
    load && !read_write_in ##1 step ##1 step |-> mem_we;
  endproperty
  a_write_uses_lanes: assert property (p_write_uses_lanes) else $error("write cycle did not write");

  property p_full_word;
    mem_we && (b_bw_n_r[LANES-1:0] == '0) |-> bit_we == live_mask;
  endproperty
  a_full_word: assert property (p_full_word) else $error("full write missed lanes");

  property p_data_captured;
    mem_we && (b_bw_n_r == 4'h0) |=> (mem[$past(b_addr_r)] & live_mask) == ($past(data_lane_in) & live_mask);
  endproperty
  a_data_captured: assert property (p_data_captured) else $error("write data not stored");

  property p_dead_bits;
    ((data_lane_oe_out | rdata_r | bit_we) & ~live_mask) == '0;
  endproperty
  a_dead_bits: assert property (p_dead_bits) else $error("unused bit position active");

  property p_linear;
    adv && !burst_order_strap_in |-> issue_addr[1:0] == BURST_W'(base_r[1:0] + cnt_r + 2'h1);
  endproperty
  a_linear: assert property (p_linear) else $error("linear burst order wrong");

  property p_interleave;
    adv && burst_order_strap_in |-> issue_addr[1:0] == (base_r[1:0] ^ BURST_W'(cnt_r + 2'h1));
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleaved burst order wrong");

  property p_read_latency;
    load && read_write_in ##1 step ##1 step |=> rd_valid_r;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read data not after two active edges");

  property p_suspend;
    !step |=> $stable(rdata_r) && $stable(cnt_r) && $stable(a_addr_r) && $stable(b_valid_r);
  endproperty
  a_suspend: assert property (p_suspend) else $error("state moved while clock suspended");

  // Each disabled lane must see no bit write, whatever the other lanes do
  property p_lane_gate;
    (!b_bw_n_r[0] || bit_we[8:0] == '0) && (!b_bw_n_r[1] || bit_we[17:9] == '0) &&
      (!b_bw_n_r[2] || bit_we[26:18] == '0) && (!b_bw_n_r[3] || bit_we[35:27] == '0);
  endproperty
  a_lane_gate: assert property (p_lane_gate) else $error("write outside enabled lane");

  property p_snooze;
    snooze_enable_in |-> !mem_we && (data_lane_oe_out == '0);
  endproperty
  a_snooze: assert property (p_snooze) else $error("activity during snooze");

  c_read_burst: cover property (load && read_write_in ##1 adv ##1 adv ##1 adv);
  c_full_write: cover property (mem_we && (b_bw_n_r == 4'h0));
  c_suspend_read: cover property (rd_valid_r && !step ##1 rd_valid_r);
  c_partial_write: cover property (mem_we && (b_bw_n_r == 4'hE));
endmodule : sync_sram_core

// ==== sram_host_bus.sv ====
// Host-side data bus model that resolves the shared data lanes
`timescale 1ns/1ps
module sram_host_bus
  import sram_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic [DQ_W-1:0] host_data_in,
  input wire logic host_en_in,
  input wire logic [DQ_W-1:0] dev_data_in,
  input wire logic [DQ_W-1:0] dev_oe_in,
  output logic [DQ_W-1:0] bus_out
);
  logic [DQ_W-1:0] last_r;
  // Bits nobody drives show the inverse of their last level
  always_comb begin
    for (int i = 0; i < DQ_W; i++) begin
      bus_out[i] = dev_oe_in[i] ? dev_data_in[i] : (host_en_in ? host_data_in[i] : ~last_r[i]);
    end
  end
  always_ff @(posedge clk_sys_in) begin
    last_r <= bus_out;
  end
endmodule : sram_host_bus

// ==== tb_top.sv ====
// Self-checking bench for the SRAM cycle and lane control
`timescale 1ns/1ps
module tb_top;
  import sram_pkg::*;
  logic clk_sys_in = 0;
  logic arst_n_in = 0;
  logic [ADDR_PIN_W-1:0] addr = '0;
  logic [EXP_PIN_W-1:0] rsv = '0;
  logic adv = 1, rw = 1, cke_n = 0, oe_n = 0, strap = 1, zz = 0, h_en = 0, r;
  logic [MAX_LANES-1:0] bw_n = 4'hF, b;
  logic [DQ_W-1:0] h_dat = '0, bus, dout, oe, rd, ro, d;
  logic [DQ_W-1:0] dout32, oe32, rd32;
  logic [DQ_W-1:0] mem [int];
  logic [16:0] a;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  integer seed = 32'hfe0d1e68;

  always #25 clk_sys_in = ~clk_sys_in;

  sync_sram_core #(.WORD_CFG(CFG_X36)) dut_u (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .sync_address_input_in(addr), .reserved_expansion_pin_in(rsv), .advance_or_load_in(adv),
    .read_write_in(rw), .clock_enable_n_in(cke_n), .byte_write_lane_n_in(bw_n),
    .output_enable_n_in(oe_n), .burst_order_strap_in(strap), .snooze_enable_in(zz),
    .data_lane_in(bus), .data_lane_out(dout), .data_lane_oe_out(oe));

  sram_host_bus host_u (.clk_sys_in(clk_sys_in), .host_data_in(h_dat), .host_en_in(h_en),
    .dev_data_in(dout), .dev_oe_in(oe), .bus_out(bus));

  // The 32-bit build only listens on the shared bus; the full build drives it
  sync_sram_core #(.WORD_CFG(CFG_X32)) dut_x32_u (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .sync_address_input_in(addr), .reserved_expansion_pin_in(rsv), .advance_or_load_in(adv),
    .read_write_in(rw), .clock_enable_n_in(cke_n), .byte_write_lane_n_in(bw_n),
    .output_enable_n_in(oe_n), .burst_order_strap_in(strap), .snooze_enable_in(zz),
    .data_lane_in(bus), .data_lane_out(dout32), .data_lane_oe_out(oe32));

  task automatic check(input string what, input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  function automatic logic [DQ_W-1:0] merge(input logic [DQ_W-1:0] o, input logic [DQ_W-1:0] n,
                                            input logic [3:0] en_n);
    for (int k = 0; k < MAX_LANES; k++) begin
      if (!en_n[k]) o[9*k +: 9] = n[9*k +: 9];
    end
    return o;
  endfunction : merge

  // Parity positions carry nothing on the 32-bit build
  function automatic logic [DQ_W-1:0] mask32();
    mask32 = '1;
    for (int k = 0; k < MAX_LANES; k++) mask32[9*k+8] = 1'b0;
  endfunction : mask32

  // One load, then two masked advances; host owns the bus only in the write data cycle
  task automatic access(input logic rd_n, input logic [16:0] ad, input logic [3:0] en_n,
                        input logic [DQ_W-1:0] wd);
    @(posedge clk_sys_in);
    adv <= 0; rw <= rd_n; bw_n <= en_n;
    addr <= {1'($random(seed)), ad};
    rsv <= 2'($random(seed));
    @(posedge clk_sys_in);
    adv <= 1; rw <= ~rd_n; bw_n <= 4'hF;
    @(posedge clk_sys_in);
    h_en <= ~rd_n; oe_n <= ~rd_n; h_dat <= wd;
    @(posedge clk_sys_in);
    h_en <= 0; oe_n <= 0;
    #1 rd = dout;
    rd32 = dout32;
  endtask : access

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys_in);
    arst_n_in <= 1;
    #1 check("out_after_reset", dout, '0);
    check("oe_after_reset", oe, '0);
    for (int j = 0; j < 4; j++) begin
      d = {4'($random(seed)), 32'($random(seed))};
      access(0, 17'(8 + j), 4'h0, d);
      mem[8 + j] = d;
    end
    for (int i = 0; i < 60; i++) begin
      a = (i % 10 == 9) ? 17'h1FFFF : 17'($random(seed) & 7);
      r = mem.exists(int'(a)) ? 1'($random(seed)) : 1'b0;
      b = mem.exists(int'(a)) ? 4'($random(seed)) : 4'h0;
      d = {4'($random(seed)), 32'($random(seed))};
      access(r, a, b, d);
      if (r) begin
        check("read_data", rd, mem[int'(a)]);
        check("read_oe", oe, '1);
        check("read_data_x32", rd32, mem[int'(a)] & mask32());
        check("read_oe_x32", oe32, mask32());
      end else begin
        mem[int'(a)] = merge(mem[int'(a)], d, b);
      end
    end
    for (int s = 0; s < 2; s++) begin
      // Strap only moves while reset holds every burst off
      @(posedge clk_sys_in);
      arst_n_in <= 0;
      strap <= s[0];
      repeat (2) @(posedge clk_sys_in);
      arst_n_in <= 1;
      @(posedge clk_sys_in);
      adv <= 0; rw <= 1; addr <= 18'h9; bw_n <= 4'hF;
      @(posedge clk_sys_in);
      adv <= 1; rw <= 0; bw_n <= 4'h0;
      @(posedge clk_sys_in);
      for (int k = 0; k < 4; k++) begin
        @(posedge clk_sys_in);
        #1 check("burst", dout, mem[8 + (s ? (1 ^ k) : ((1 + k) % 4))]);
      end
    end
    for (int f = 0; f < 2; f++) begin
      access(1, 17'h8, 4'hF, '0);
      @(posedge clk_sys_in);
      cke_n <= ~f[0]; zz <= f[0]; adv <= 0; rw <= 0; bw_n <= 4'h0;
      #1 rd = dout;
      ro = oe;
      repeat (3) @(posedge clk_sys_in);
      #1 check("frozen_out", dout, rd);
      check("frozen_oe", oe, f ? '0 : ro);
      @(posedge clk_sys_in);
      cke_n <= 0; zz <= 0; adv <= 1; bw_n <= 4'hF;
      access(1, 17'h8, 4'hF, '0);
      check("no_write_frozen", rd, mem[8]);
    end
    conclude();
  end
endmodule : tb_top
